// >>> design/edt_timer.sv
// Eight-bit down-counter timer with prescaler, pin logic and Avalon slave
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none
`include "edt_timer_cfg.svh"

module edt_timer (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [7:0]                  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [31:0]                 avs_writedata,
  input  wire logic [3:0]                  avs_byteenable,
  output var  logic [31:0]                 avs_readdata,
  output var  logic                        avs_waitrequest,
  input  wire logic                        timerPinIn,
  output var  logic                        timerPinOut,
  output var  logic                        timerPinOe_n,
  output var  logic                        timerIrq,
  output var  logic                        timerWake
);
  import edt_timer_pkg::*;

  edt_timer_pkg::edt_avm_req_t req;
  edt_timer_pkg::edt_ctrl_t    ctrlReg;
  edt_timer_pkg::edt_ctrl_t    ctrlNext;
  edt_bus_state_t busReg;
  edt_bus_state_t busNext;
  logic [6:0]  prescReg;
  logic [6:0]  prescNext;
  logic [6:0]  prescPrev;
  logic [7:0]  countReg;
  logic [7:0]  countNext;
  logic [3:0]  div12Reg;
  logic [1:0]  irqStatReg;
  logic [1:0]  irqMaskReg;
  logic [31:0] rdataReg;
  logic        pinOutReg;
  logic        pinOeReg;
  logic        irqReg;
  logic        wakeReg;
  logic        pinLevel;
  logic        pinRise;

  edt_pin_sync u_sync (
    .clk   (clk),
    .rst   (rst),
    .pinIn (timerPinIn),
    .level (pinLevel),
    .rise  (pinRise)
  );

  function automatic logic wordHit(input logic [7:0] a, input logic [7:0] off);
    wordHit = (a == off);
  endfunction

  assign req = '{avs_address, avs_read, avs_write, avs_writedata,
                 avs_byteenable};

  // Request seen in IDLE, accepted one cycle later in RESP with waitrequest low
  wire       busAccept = (busReg == EDT_RESP);
  wire       wrLane0   = busAccept && req.write && req.byteenable[0];
  wire [7:0] wrByte    = req.writedata[7:0];
  wire       wrPresc   = wrLane0 && wordHit(req.address, `EDT_OFF_PRESCALER);
  wire       wrCount   = wrLane0 && wordHit(req.address, `EDT_OFF_COUNTER);
  wire       wrCtrl    = wrLane0 && wordHit(req.address, `EDT_OFF_CTRL);
  wire       wrStat    = wrLane0 && wordHit(req.address, `EDT_OFF_IRQ_STATUS);
  wire       wrMask    = wrLane0 && wordHit(req.address, `EDT_OFF_IRQ_MASK);

  // Mode from direction and data bits
  wire edt_mode_t mode = ctrlReg.pinDirection ? EDT_OUTPUT :
                         (ctrlReg.pinData ? EDT_GATED : EDT_EVENT);

  wire div12Tick = (div12Reg == `EDT_INT_DIV - 4'd1);
  // Gated mode uses the synchronised level, so gate edges lag by 4 cycles
  wire srcTick = (mode == EDT_EVENT) ? pinRise :
                 (mode == EDT_GATED) ? (div12Tick && pinLevel) :
                 div12Tick;

  wire prescStep = ctrlReg.prescalerRun && srcTick;
  assign prescPrev = prescReg;
  // Code n ticks on falls of bit n-1, once every 2^n prescaler steps
  wire [6:0] prescDec = (prescReg == 7'h00) ? `EDT_RST_PRESCALER
                                            : prescReg - 7'h01;
  wire [7:0] tapMask  = 8'h01 << (ctrlReg.dividerSelect - 3'd1);
  wire [7:0] prevExt  = {1'b0, prescPrev};
  wire [7:0] decExt   = {1'b0, prescDec};
  wire       tapTick  = (ctrlReg.dividerSelect == 3'd0) ||
                        (((prevExt ^ decExt) & tapMask & ~decExt) != 8'h00);
  wire countStep = prescStep && tapTick;
  wire wrapNow   = countStep && (countReg == 8'h00) && !wrCount;
  wire flagRise  = !ctrlReg.underflowFlag && ctrlNext.underflowFlag;

  always_comb begin
    prescNext = prescReg;
    if (!ctrlReg.prescalerRun) begin
      prescNext = `EDT_RST_PRESCALER;
    end else if (wrPresc) begin
      prescNext = wrByte[6:0];
    end else if (prescStep) begin
      prescNext = prescDec;
    end
  end

  always_comb begin
    countNext = countReg;
    if (wrCount) begin
      countNext = wrByte;
    end else if (countStep) begin
      countNext = countReg - 8'h01;
    end
  end

  always_comb begin
    ctrlNext = ctrlReg;
    if (wrCtrl) begin
      ctrlNext = edt_ctrl_t'(wrByte);
    end
    // Wrap sets the flag; only software writes clear it
    if (wrapNow) begin
      ctrlNext.underflowFlag = 1'b1;
    end
  end

  wire [7:0] rdPresc = {1'b0, prescReg};
  wire [31:0] rdMux =
    wordHit(req.address, `EDT_OFF_PRESCALER)  ? {24'h000000, rdPresc} :
    wordHit(req.address, `EDT_OFF_COUNTER)    ? {24'h000000, countReg} :
    wordHit(req.address, `EDT_OFF_CTRL)       ? {24'h000000, ctrlReg} :
    wordHit(req.address, `EDT_OFF_IRQ_STATUS) ? {30'h0, irqStatReg} :
    wordHit(req.address, `EDT_OFF_IRQ_MASK)   ? {30'h0, irqMaskReg} :
    32'h00000000;

  assign busNext = ((busReg == EDT_IDLE) && (req.read || req.write)) ?
                   EDT_RESP : EDT_IDLE;

  // Status events: bit0 underflow, bit1 pin rising edge in input mode
  wire [1:0] evSet  = {pinRise && !ctrlReg.pinDirection, wrapNow};
  wire [1:0] evClr  = wrStat ? wrByte[1:0] : 2'b00;
  wire [1:0] statNx = (irqStatReg & ~evClr) | evSet;

  always_ff @(posedge clk) begin
    if (rst) begin
      prescReg <= `EDT_RST_PRESCALER;
      countReg <= `EDT_RST_COUNTER;
      ctrlReg  <= edt_ctrl_t'(`EDT_RST_CTRL);
      busReg   <= EDT_IDLE;
    end else begin
      prescReg <= prescNext;
      countReg <= countNext;
      ctrlReg  <= ctrlNext;
      busReg   <= busNext;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      div12Reg <= 4'd0;
    end else if (div12Tick) begin
      div12Reg <= 4'd0;
    end else begin
      div12Reg <= div12Reg + 4'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irqStatReg <= 2'b00;
      irqMaskReg <= 2'b00;
      rdataReg   <= 32'h00000000;
    end else begin
      irqStatReg <= statNx;
      if (wrMask) begin
        irqMaskReg <= wrByte[1:0];
      end
      rdataReg <= (busReg == EDT_IDLE) ? rdMux : rdataReg;
    end
  end

  // Pin latch is updated only on a flag rise, whether from a wrap or a software write
  always_ff @(posedge clk) begin
    if (rst) begin
      pinOutReg <= 1'b0;
      pinOeReg  <= 1'b1;
      irqReg    <= 1'b0;
      wakeReg   <= 1'b0;
    end else begin
      if (flagRise) begin
        pinOutReg <= ctrlNext.pinData;
      end
      pinOeReg <= !ctrlNext.pinDirection;
      irqReg   <= ((statNx & irqMaskReg) != 2'b00);
      wakeReg  <= ctrlNext.underflowFlag && ctrlNext.irqEnable;
    end
  end

  assign avs_readdata    = rdataReg;
  assign avs_waitrequest = !busAccept;
  assign timerPinOut     = pinOutReg;
  assign timerPinOe_n    = pinOeReg;
  assign timerIrq        = irqReg;
  assign timerWake       = wakeReg;
endmodule
`default_nettype wire

// >>> design/edt_timer_cfg.svh
// Offsets, field positions, reset values and timing counts of the timer
`ifndef EDT_TIMER_CFG_SVH
`define EDT_TIMER_CFG_SVH
`define EDT_OFF_PRESCALER   8'hD2
`define EDT_OFF_COUNTER     8'hD3
`define EDT_OFF_CTRL        8'hD4
`define EDT_OFF_IRQ_STATUS  8'hD5
`define EDT_OFF_IRQ_MASK    8'hD6
`define EDT_RST_PRESCALER   7'h7F
`define EDT_RST_COUNTER     8'hFF
`define EDT_RST_CTRL        8'h00
`define EDT_BIT_FLAG        7
`define EDT_BIT_IRQEN       6
`define EDT_BIT_DIR         5
`define EDT_BIT_DATA        4
`define EDT_BIT_RUN         3
`define EDT_INT_DIV         4'd12
`endif

// >>> design/edt_timer_pkg.sv
// Types shared by the timer files
package edt_timer_pkg;
  typedef struct packed {
    logic       underflowFlag;
    logic       irqEnable;
    logic       pinDirection;
    logic       pinData;
    logic       prescalerRun;
    logic [2:0] dividerSelect;
  } edt_ctrl_t;
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } edt_avm_req_t;
  typedef enum logic [1:0] {
    EDT_EVENT  = 2'b00,
    EDT_GATED  = 2'b01,
    EDT_OUTPUT = 2'b10
  } edt_mode_t;
  typedef enum logic [1:0] {
    EDT_IDLE = 2'b00,
    EDT_RESP = 2'b01
  } edt_bus_state_t;
endpackage

// >>> design/edt_pin_sync.sv
// Three-stage pin synchroniser with rising-edge detect
`timescale 1ns/100ps
`default_nettype none
module edt_pin_sync (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic pinIn,
  output var  logic level,
  output var  logic rise
);
  logic s1Reg;
  logic s2Reg;
  logic s3Reg;
  logic levelReg;

  // Change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (rst) begin
      // Reset to the pulled-up idle level, so no false edge follows reset
      s1Reg    <= 1'b1;
      s2Reg    <= 1'b1;
      s3Reg    <= 1'b1;
      levelReg <= 1'b1;
    end else begin
      s1Reg <= pinIn;
      s2Reg <= s1Reg;
      s3Reg <= s2Reg;
      if (s2Reg == s3Reg) begin
        levelReg <= s3Reg;
      end
    end
  end

  assign level = levelReg;
  assign rise  = (s2Reg == s3Reg) && s3Reg && !levelReg;
endmodule
`default_nettype wire

// >>> tb/edt_timer_checker.sv
// Concurrent checks on the timer's bus and pin ports
`timescale 1ns/100ps
`default_nettype none
module edt_timer_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        timerPinOe_n,
  input wire logic        timerWake
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic wrCtrl;
  assign wrCtrl = avs_write && !avs_waitrequest &&
                  avs_address == 8'hD4 && avs_byteenable[0];
  sequence outSel; wrCtrl && avs_writedata[5]; endsequence
  sequence inSel; wrCtrl && !avs_writedata[5]; endsequence
  sequence wakeSet; wrCtrl && avs_writedata[7] && avs_writedata[6];
  endsequence
  a_reset_state: assert property ($fell(rst) |-> avs_waitrequest &&
    timerPinOe_n && !timerWake) else $error("reset state wrong");
  a_dir_output: assert property (outSel |-> ##[1:2] !timerPinOe_n)
    else $error("pin not driven");
  a_dir_input: assert property (inSel |-> ##[1:2] timerPinOe_n)
    else $error("pin not released");
  a_psc_msb: assert property (avs_read && !avs_waitrequest &&
    avs_address == 8'hD2 |-> !avs_readdata[7]) else $error("bit 7 set");
  a_upper_zero: assert property (avs_readdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_wake_set: assert property (wakeSet |-> ##[1:3] timerWake)
    else $error("wake missing");
  a_wake_sticky: assert property ($fell(timerWake) |->
    $past(wrCtrl) || $past(wrCtrl, 2)) else $error("flag self cleared");
  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
    |-> ##[1:2] !avs_waitrequest) else $error("no bus answer");
  a_idle_wait: assert property (!avs_read && !avs_write |-> avs_waitrequest)
    else $error("waitrequest low while idle");
endmodule
bind edt_timer edt_timer_checker chk (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .timerPinOe_n(timerPinOe_n), .timerWake(timerWake));
`default_nettype wire

// >>> tb/edt_pin_model.sv
// Signal source on the timer pin, passing extLevel when undriven
`timescale 1ns/100ps
`default_nettype none
module edt_pin_model (
  input  wire logic timerPinOut,
  input  wire logic timerPinOe_n,
  input  wire logic extLevel,
  output wire logic timerPinIn
);
  // Push-pull output overrides the source while driven
  assign timerPinIn = timerPinOe_n ? extLevel : timerPinOut;
endmodule
`default_nettype wire

// >>> tb/edt_timer_bench.sv
// Self-checking bench for the down-counter timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  err_total++; $display("BAD %s exp %h got %h", n, e, g); end end
module edt_timer_bench;
  import edt_timer_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  busAdr = 8'h00;
  logic        busRd = 1'b0;
  logic        busWr = 1'b0;
  logic [31:0] busWd = 32'h0;
  logic [31:0] rdData;
  logic        waitReq, pinIn, pinOut, pinOe_n, irq, wake;
  logic        extLevel = 1'b1;
  int          err_total = 0;
  int          compares = 0;
  int          cycles = 0;
  logic        waitS = 1'b1;
  logic [31:0] rdS = 32'h0;
  // Mid-cycle copies hold what the next rising edge samples
  always @(negedge clk) begin
    waitS <= waitReq;
    rdS <= rdData;
  end
  always #4 clk = ~clk;
  edt_timer DUT (.clk(clk), .rst(rst), .avs_address(busAdr),
    .avs_read(busRd), .avs_write(busWr), .avs_writedata(busWd),
    .avs_byteenable(4'hF), .avs_readdata(rdData), .avs_waitrequest(waitReq),
    .timerPinIn(pinIn), .timerPinOut(pinOut), .timerPinOe_n(pinOe_n),
    .timerIrq(irq), .timerWake(wake));
  edt_pin_model pin (.timerPinOut(pinOut), .timerPinOe_n(pinOe_n),
    .extLevel(extLevel), .timerPinIn(pinIn));
  task automatic bus_op(input logic [7:0] a, input logic w,
                        input logic [7:0] d, output logic [7:0] q);
    busAdr <= a;
    busWd <= {24'h0, d};
    busRd <= !w;
    busWr <= w;
    @(posedge clk);
    while (waitS) @(posedge clk);
    q = rdS[7:0];
    busRd <= 1'b0;
    busWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus_op(a, 1'b1, d, q);
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, e);
    logic [7:0] q;
    bus_op(a, 1'b0, 8'h00, q);
    `CHK(n, e, q)
  endtask
  task automatic t_reset;
    rd_chk("psc", 8'hD2, 8'h7F);
    rd_chk("cnt", 8'hD3, 8'hFF);
    rd_chk("ctrl", 8'hD4, 8'h00);
    `CHK("oe_n", 1'b1, pinOe_n)
    repeat (40) @(posedge clk);
    rd_chk("frozen", 8'hD3, 8'hFF);
    rd_chk("unmapped", 8'hD7, 8'h00);
  endtask
  task automatic t_wake;
    wr(8'hD4, 8'hC0);
    repeat (20) @(posedge clk);
    `CHK("wake", 1'b1, wake)
    rd_chk("sticky", 8'hD4, 8'hC0);
    wr(8'hD4, 8'h40);
    repeat (2) @(posedge clk);
    `CHK("wake off", 1'b0, wake)
  endtask
  task automatic t_output;
    logic [7:0] q;
    wr(8'hD6, 8'h01);
    wr(8'hD3, 8'h01);
    wr(8'hD4, 8'h38);
    @(negedge clk);
    `CHK("pin early", 1'b0, pinOut)
    `CHK("driven", 1'b0, pinOe_n)
    @(posedge clk);
    q = 8'h00;
    for (int i = 0; i < 40 && !q[7]; i++) bus_op(8'hD4, 1'b0, 8'h00, q);
    `CHK("flag", 1'b1, q[7])
    bus_op(8'hD3, 1'b0, 8'h00, q);
    `CHK("reload", 1'b1, q >= 8'hFD)
    @(negedge clk);
    `CHK("pin high", 1'b1, pinOut)
    `CHK("irq", 1'b1, irq)
    @(posedge clk);
    wr(8'hD6, 8'h00);
    @(negedge clk);
    `CHK("masked", 1'b0, irq)
    @(posedge clk);
    wr(8'hD6, 8'h01);
    wr(8'hD5, 8'h01);
    @(negedge clk);
    `CHK("cleared", 1'b0, irq)
    @(posedge clk);
  endtask
  task automatic t_input;
    logic [7:0] q;
    wr(8'hD4, 8'h00);
    rd_chk("psc init", 8'hD2, 8'h7F);
    extLevel <= 1'b0;
    // Let the low level pass the synchroniser before counting starts
    repeat (6) @(posedge clk);
    wr(8'hD4, 8'h18);
    repeat (50) @(posedge clk);
    rd_chk("gate low", 8'hD2, 8'h7F);
    extLevel <= 1'b1;
    repeat (40) @(posedge clk);
    bus_op(8'hD2, 1'b0, 8'h00, q);
    `CHK("gate high", 1'b1, q < 8'h7F)
    wr(8'hD4, 8'h00);
    wr(8'hD4, 8'h08);
    repeat (3) begin
      extLevel <= 1'b0;
      repeat (6) @(posedge clk);
      extLevel <= 1'b1;
      repeat (6) @(posedge clk);
    end
    rd_chk("events", 8'hD2, 8'h7C);
    wr(8'hD3, 8'h10);
    wr(8'hD4, 8'h09);
    repeat (4) begin
      extLevel <= 1'b0;
      repeat (6) @(posedge clk);
      extLevel <= 1'b1;
      repeat (6) @(posedge clk);
    end
    rd_chk("div2", 8'hD3, 8'h0E);
  endtask
  task automatic stop_test;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Bench stalls are cut short here
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      stop_test;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset;
    t_wake;
    t_output;
    t_input;
    stop_test;
  end
endmodule
`default_nettype wire
